//--- logic/pfs_pkg.sv
// constants and types shared by the fault and gpio supervisor
`default_nettype none
package pfs_pkg;
  // ------------------------------------------------------------
  // sizes and timing
  // ------------------------------------------------------------
  localparam int NUM_OUT = 6;
  localparam int NUM_BUCK = 4;
  localparam int NUM_PIN = 8;
  localparam int CLK_HZ = 25_000_000;
  localparam int GLOBAL_OFF_MS = 200;
  localparam int RETRY_MS = 14;
  localparam int GLOBAL_OFF_CYC = CLK_HZ / 1000 * GLOBAL_OFF_MS;
  localparam int RETRY_CYC = CLK_HZ / 1000 * RETRY_MS;
  localparam int TMR_W = 23;
  localparam int RUN_W = 6;
  localparam logic [RUN_W-1:0] WARN_RUN = 6'h10;
  localparam logic [RUN_W-1:0] HARD_RUN = 6'h02;
  localparam logic [RUN_W-1:0] SHORT_RUN = 6'h20;
  // ------------------------------------------------------------
  // fault bit positions in the latched fault vector
  // ------------------------------------------------------------
  localparam int FB_UVOV = 0;
  localparam int FB_CURRENT_LIMIT_STATUS = 1;
  localparam int FB_TWARN = 2;
  localparam int FB_TSHD = 3;
  localparam int NUM_FB = 4;
  // ------------------------------------------------------------
  // gpio functions and their defaults
  // ------------------------------------------------------------
  localparam int FN_W = 3;
  localparam logic [FN_W-1:0] FN_INPUT = 3'h0;
  localparam logic [FN_W-1:0] FN_RESET = 3'h1;
  localparam logic [FN_W-1:0] FN_IRQ = 3'h2;
  localparam logic [FN_W-1:0] FN_PWREN = 3'h3;
  localparam logic [FN_W-1:0] FN_EXT_EN = 3'h4;
  localparam logic [FN_W-1:0] FN_BUTTON = 3'h5;
  localparam logic [FN_W-1:0] FN_LED = 3'h6;
  localparam logic [FN_W-1:0] FN_MODE = 3'h7;
  localparam logic [NUM_PIN*FN_W-1:0] FN_DEFAULT = 24'h8C7FF9;
  localparam logic [NUM_PIN-1:0] TRI_PINS = 8'h1E;
  localparam logic [NUM_PIN-1:0] BUTTON_OK = 8'h60;
  localparam logic [NUM_PIN-1:0] LED_OK = 8'h80;
  localparam int SETTLE_CYC = 16;
  localparam int SET_W = 5;
  // three-level codes
  localparam logic [1:0] LV_LOW = 2'h0;
  localparam logic [1:0] LV_FLOAT = 2'h1;
  localparam logic [1:0] LV_HIGH = 2'h2;
  typedef enum logic [2:0] {
    PFS_ST_START, PFS_ST_ACTIVE, PFS_ST_OVUV, PFS_ST_THERM, PFS_ST_VINOV
  } pfs_state_t;
endpackage : pfs_pkg
`default_nettype wire

//--- logic/pfs_oc_run.sv
// consecutive switching-cycle run counter for one overcurrent threshold
`default_nettype none
module pfs_oc_run (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // one pulse per switching cycle, with the sampled comparison
  input wire logic cyc,
  input wire logic over,
  input wire logic [pfs_pkg::RUN_W-1:0] limit,
  input wire logic strict,
  // trip level
  output logic trip
);
  logic [pfs_pkg::RUN_W-1:0] run;

  // saturate so a long run does not wrap and drop the trip
  always_ff @(posedge clk) begin
    if (rst) begin
      run <= '0;
    end else if (cyc) begin
      if (!over) begin
        run <= '0;
      end else if (run != {pfs_pkg::RUN_W{1'b1}}) begin
        run <= run + 1'b1;
      end
    end
  end

  // strict means "more than" the count, otherwise "reached"
  always_ff @(posedge clk) begin
    if (rst) begin
      trip <= 1'b0;
    end else begin
      trip <= strict ? (run > limit) : (run >= limit);
    end
  end
endmodule : pfs_oc_run
`default_nettype wire

//--- logic/pfs_strap.sv
// power-up sampling and latching of the three-level strap pins
`default_nettype none
module pfs_strap (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin levels: driven high, driven low, and weak-bias reading
  input wire logic [pfs_pkg::NUM_PIN-1:0] pin_in,
  input wire logic [pfs_pkg::NUM_PIN-1:0] pin_float,
  // latched result, two bits per pin
  output logic [2*pfs_pkg::NUM_PIN-1:0] strap_level,
  output logic strap_done,
  output logic bias_en
);
  logic [pfs_pkg::SET_W-1:0] settle;

  // wait for the bias to settle, then take one sample only
  always_ff @(posedge clk) begin
    if (rst) begin
      settle <= '0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      if (settle == pfs_pkg::SET_W'(pfs_pkg::SETTLE_CYC)) begin
        strap_done <= 1'b1;
      end else begin
        settle <= settle + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      strap_level <= '0;
    end else if (!strap_done && settle ==
                 pfs_pkg::SET_W'(pfs_pkg::SETTLE_CYC)) begin
      for (int i = 0; i < pfs_pkg::NUM_PIN; i++) begin
        if (pfs_pkg::TRI_PINS[i]) begin
          strap_level[2*i +: 2] <= pin_float[i] ? pfs_pkg::LV_FLOAT :
            (pin_in[i] ? pfs_pkg::LV_HIGH : pfs_pkg::LV_LOW);
        end
      end
    end
  end

  // bias only until the latch, saves io supply current afterwards
  always_ff @(posedge clk) begin
    if (rst) begin
      bias_en <= 1'b1;
    end else begin
      bias_en <= !strap_done && settle !=
                 pfs_pkg::SET_W'(pfs_pkg::SETTLE_CYC);
    end
  end
endmodule : pfs_strap
`default_nettype wire

//--- logic/pfs_supervisor.sv
// fault supervisor, restart sequencing and gpio function control
`default_nettype none
module pfs_supervisor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // output rail monitors
  input wire logic [pfs_pkg::NUM_OUT-1:0] out_uv,
  input wire logic [pfs_pkg::NUM_OUT-1:0] out_ov,
  input wire logic [pfs_pkg::NUM_OUT-1:0] overvoltage_mask_bit_wr,
  input wire logic [pfs_pkg::NUM_OUT-1:0] undervoltage_mask_bit_wr,
  input wire logic mask_wr,
  input wire logic fault_shutdown_disable,
  // buck current sensing, one cycle pulse per switching cycle
  input wire logic [pfs_pkg::NUM_BUCK-1:0] sw_cycle,
  input wire logic buck1_warn_level,
  input wire logic buck1_hard_level,
  input wire logic [pfs_pkg::NUM_BUCK-1:0] buck_at_limit,
  input wire logic [pfs_pkg::NUM_BUCK-1:0] current_limit_shutdown_enable,
  input wire logic [pfs_pkg::NUM_BUCK-1:0] current_limit_mask_bit_wr,
  // thermal and input monitors
  input wire logic temp_warn,
  input wire logic temp_shd,
  input wire logic thermal_warn_mask_wr,
  input wire logic thermal_shd_mask_wr,
  input wire logic input_overvoltage_level,
  input wire logic power_seq_done,
  // fault bit read strobe, one per fault bit
  input wire logic [pfs_pkg::NUM_FB-1:0] fault_read,
  // gpio pins and function writes
  input wire logic [pfs_pkg::NUM_PIN-1:0] pin_in,
  input wire logic [pfs_pkg::NUM_PIN-1:0] pin_float,
  input wire logic fn_wr,
  input wire logic [2:0] fn_wr_pin,
  input wire logic [pfs_pkg::FN_W-1:0] fn_wr_val,
  // rail enables and status
  output logic [pfs_pkg::NUM_OUT-1:0] rail_en,
  output logic [pfs_pkg::NUM_OUT-1:0] uv_flag,
  output logic [pfs_pkg::NUM_OUT-1:0] ov_flag,
  output logic [pfs_pkg::NUM_BUCK-1:0] current_limit_status,
  output logic thermal_warn_flag,
  output logic thermal_shd_flag,
  output logic [pfs_pkg::NUM_FB-1:0] fault_bits,
  output logic restart_seq,
  output logic [2:0] state_code,
  // host pins
  output logic reset_out_n,
  output logic interrupt_out_n,
  // gpio side
  output logic [pfs_pkg::NUM_PIN*pfs_pkg::FN_W-1:0] pin_fn,
  output logic fn_wr_reject,
  output logic [2*pfs_pkg::NUM_PIN-1:0] strap_level,
  output logic strap_done,
  output logic io_supply_bias_en
);
  // ------------------------------------------------------------
  // masks and state
  // ------------------------------------------------------------
  pfs_pkg::pfs_state_t state;
  pfs_pkg::pfs_state_t next_state;
  logic [pfs_pkg::NUM_OUT-1:0] ov_mask;
  logic [pfs_pkg::NUM_OUT-1:0] uv_mask;
  logic [pfs_pkg::NUM_BUCK-1:0] current_limit_status_mask;
  logic twarn_mask;
  logic tshd_mask;
  logic [pfs_pkg::TMR_W-1:0] gtmr;
  logic [pfs_pkg::TMR_W-1:0] rtmr [pfs_pkg::NUM_BUCK];
  logic [pfs_pkg::NUM_BUCK-1:0] buck_off;
  logic [pfs_pkg::NUM_BUCK-1:0] run16;
  logic [pfs_pkg::NUM_BUCK-1:0] run32;
  logic b1_warn;
  logic b1_hard;
  logic uvov_watch;
  logic uvov_event;
  logic [pfs_pkg::NUM_FB-1:0] fault_now;
  logic [pfs_pkg::NUM_FB-1:0] fault_set;
  logic gtmr_done;

  function automatic logic gtmr_hit(input logic [pfs_pkg::TMR_W-1:0] t,
                                    input int n);
    gtmr_hit = t >= pfs_pkg::TMR_W'(n - 1);
  endfunction : gtmr_hit

  // masks set after reset; software clears via write strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      ov_mask <= '1;
      uv_mask <= '1;
      current_limit_status_mask <= '1;
      twarn_mask <= 1'b1;
      tshd_mask <= 1'b1;
    end else if (mask_wr) begin
      ov_mask <= overvoltage_mask_bit_wr;
      uv_mask <= undervoltage_mask_bit_wr;
      current_limit_status_mask <= current_limit_mask_bit_wr;
      twarn_mask <= thermal_warn_mask_wr;
      tshd_mask <= thermal_shd_mask_wr;
    end
  end

  // ------------------------------------------------------------
  // overcurrent run counters
  // ------------------------------------------------------------
  pfs_oc_run u_b1_warn (
    .clk(clk), .rst(rst), .cyc(sw_cycle[0]), .over(buck1_warn_level),
    .limit(pfs_pkg::WARN_RUN), .strict(1'b1), .trip(b1_warn)
  );
  pfs_oc_run u_b1_hard (
    .clk(clk), .rst(rst), .cyc(sw_cycle[0]), .over(buck1_hard_level),
    .limit(pfs_pkg::HARD_RUN), .strict(1'b1), .trip(b1_hard)
  );

  for (genvar b = 1; b < pfs_pkg::NUM_BUCK; b++) begin : g_buck
    pfs_oc_run u_r16 (
      .clk(clk), .rst(rst), .cyc(sw_cycle[b]), .over(buck_at_limit[b]),
      .limit(pfs_pkg::WARN_RUN), .strict(1'b0), .trip(run16[b])
    );
    pfs_oc_run u_r32 (
      .clk(clk), .rst(rst), .cyc(sw_cycle[b]), .over(buck_at_limit[b]),
      .limit(pfs_pkg::SHORT_RUN), .strict(1'b0), .trip(run32[b])
    );
  end
  assign run16[0] = b1_warn;
  assign run32[0] = 1'b0;

  // ------------------------------------------------------------
  // real-time flags
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      uv_flag <= '0;
      ov_flag <= '0;
      current_limit_status <= '0;
      thermal_warn_flag <= 1'b0;
      thermal_shd_flag <= 1'b0;
    end else begin
      uv_flag <= out_uv;
      ov_flag <= out_ov;
      current_limit_status <= run16;
      thermal_warn_flag <= temp_warn;
      thermal_shd_flag <= temp_shd;
    end
  end

  // an output counts only while both its masks and the disable are clear
  always_comb begin
    uvov_event = 1'b0;
    for (int i = 0; i < pfs_pkg::NUM_OUT; i++) begin
      if (!ov_mask[i] && !uv_mask[i] && !fault_shutdown_disable) begin
        uvov_event = uvov_event | out_uv[i] | out_ov[i];
      end
    end
  end
  assign uvov_watch = uvov_event;

  // ------------------------------------------------------------
  // latched fault bits, set wins over read
  // ------------------------------------------------------------
  always_comb begin
    fault_now = '0;
    fault_now[pfs_pkg::FB_UVOV] = |(out_uv | out_ov);
    fault_now[pfs_pkg::FB_CURRENT_LIMIT_STATUS] = |run16;
    fault_now[pfs_pkg::FB_TWARN] = temp_warn;
    fault_now[pfs_pkg::FB_TSHD] = temp_shd;
    fault_set = '0;
    fault_set[pfs_pkg::FB_UVOV] = |((out_uv | out_ov) & ~(ov_mask | uv_mask));
    fault_set[pfs_pkg::FB_CURRENT_LIMIT_STATUS] = |(run16 & ~current_limit_status_mask);
    fault_set[pfs_pkg::FB_TWARN] = temp_warn && !twarn_mask;
    fault_set[pfs_pkg::FB_TSHD] = temp_shd && !tshd_mask;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fault_bits <= '0;
    end else begin
      for (int i = 0; i < pfs_pkg::NUM_FB; i++) begin
        if (fault_set[i]) begin
          fault_bits[i] <= 1'b1;
        end else if (fault_read[i] && !fault_now[i]) begin
          fault_bits[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      interrupt_out_n <= 1'b1;
    end else begin
      interrupt_out_n <= ~(|fault_bits);
    end
  end

  // ------------------------------------------------------------
  // global state machine
  // ------------------------------------------------------------
  assign gtmr_done = gtmr_hit(gtmr, pfs_pkg::GLOBAL_OFF_CYC);

  always_comb begin
    next_state = state;
    unique case (state)
      pfs_pkg::PFS_ST_START: begin
        if (power_seq_done) next_state = pfs_pkg::PFS_ST_ACTIVE;
      end
      pfs_pkg::PFS_ST_ACTIVE: begin
        if (input_overvoltage_level) begin
          next_state = pfs_pkg::PFS_ST_VINOV;
        end else if (temp_shd && !tshd_mask) begin
          next_state = pfs_pkg::PFS_ST_THERM;
        end else if (uvov_watch) begin
          next_state = pfs_pkg::PFS_ST_OVUV;
        end
      end
      pfs_pkg::PFS_ST_OVUV: begin
        if (gtmr_done) next_state = pfs_pkg::PFS_ST_START;
      end
      pfs_pkg::PFS_ST_THERM: begin
        if (!temp_shd) next_state = pfs_pkg::PFS_ST_START;
      end
      pfs_pkg::PFS_ST_VINOV: begin
        if (!input_overvoltage_level) begin
          next_state = pfs_pkg::PFS_ST_START;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= pfs_pkg::PFS_ST_START;
    end else begin
      state <= next_state;
    end
  end

  // the delay restarts from zero at every fault entry
  always_ff @(posedge clk) begin
    if (rst || state != pfs_pkg::PFS_ST_OVUV) begin
      gtmr <= '0;
    end else if (!gtmr_done) begin
      gtmr <= gtmr + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // per-buck shutdown and 14ms retry
  // ------------------------------------------------------------
  for (genvar b = 0; b < pfs_pkg::NUM_BUCK; b++) begin : g_retry
    logic trip_b;
    if (b == 0) begin : g_b1
      assign trip_b = b1_hard;
    end else begin : g_bx
      assign trip_b = run32[b] && current_limit_shutdown_enable[b] &&
                      !current_limit_status_mask[b] && fault_shutdown_disable;
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        buck_off[b] <= 1'b0;
        rtmr[b] <= '0;
      end else if (trip_b && !buck_off[b]) begin
        buck_off[b] <= 1'b1;
        rtmr[b] <= '0;
      end else if (buck_off[b]) begin
        if (gtmr_hit(rtmr[b], pfs_pkg::RETRY_CYC)) begin
          buck_off[b] <= 1'b0;
        end else begin
          rtmr[b] <= rtmr[b] + 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // rail enables, restart request and reset pin
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rail_en <= '0;
      restart_seq <= 1'b0;
      reset_out_n <= 1'b0;
    end else begin
      rail_en <= '0;
      if (next_state == pfs_pkg::PFS_ST_ACTIVE) begin
        rail_en <= {{(pfs_pkg::NUM_OUT-pfs_pkg::NUM_BUCK){1'b1}}, ~buck_off};
      end
      restart_seq <= next_state == pfs_pkg::PFS_ST_START &&
                     state != pfs_pkg::PFS_ST_START;
      reset_out_n <= !(|(out_uv | out_ov)) &&
                     next_state == pfs_pkg::PFS_ST_ACTIVE;
    end
  end
  assign state_code = 3'(state);

  // ------------------------------------------------------------
  // gpio straps and function assignment
  // ------------------------------------------------------------
  pfs_strap u_strap (
    .clk(clk), .rst(rst), .pin_in(pin_in), .pin_float(pin_float),
    .strap_level(strap_level), .strap_done(strap_done),
    .bias_en(io_supply_bias_en)
  );

  // three-level pins stay fixed; button and led only where supported
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_fn <= pfs_pkg::FN_DEFAULT;
      fn_wr_reject <= 1'b0;
    end else begin
      fn_wr_reject <= 1'b0;
      if (fn_wr) begin
        if (pfs_pkg::TRI_PINS[fn_wr_pin] ||
            (fn_wr_val == pfs_pkg::FN_BUTTON &&
             !pfs_pkg::BUTTON_OK[fn_wr_pin]) ||
            (fn_wr_val == pfs_pkg::FN_LED && !pfs_pkg::LED_OK[fn_wr_pin]) ||
            fn_wr_val == pfs_pkg::FN_MODE) begin
          fn_wr_reject <= 1'b1;
        end else begin
          pin_fn[fn_wr_pin*pfs_pkg::FN_W +: pfs_pkg::FN_W] <= fn_wr_val;
        end
      end
    end
  end
endmodule : pfs_supervisor
`default_nettype wire

//--- dv/pfs_host_model.sv
// stand-in for the power-up sequencer that answers the supervisor
`default_nettype none
module pfs_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // supervisor state and sequence answer
  input wire logic [2:0] state_code,
  output logic power_seq_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // answers slowly on purpose, so the start state is seen to hold
  always_ff @(posedge clk) begin
    if (rst || state_code != 3'h0) begin
      cnt <= 4'h0;
      power_seq_done <= 1'h0;
    end else if (cnt == 4'hF) begin
      power_seq_done <= 1'h1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : pfs_host_model
`default_nettype wire

//--- dv/pfs_checker_sva.sv
// concurrent checks on the supervisor's ports
`default_nettype none
module pfs_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // monitors and writes
  input wire logic [5:0] out_uv,
  input wire logic [5:0] out_ov,
  input wire logic [5:0] overvoltage_mask_bit_wr,
  input wire logic [5:0] undervoltage_mask_bit_wr,
  input wire logic mask_wr,
  input wire logic fault_shutdown_disable,
  input wire logic temp_warn,
  input wire logic temp_shd,
  input wire logic [3:0] fault_read,
  input wire logic fn_wr,
  input wire logic [2:0] fn_wr_pin,
  input wire logic [2:0] fn_wr_val,
  // design outputs
  input wire logic [5:0] rail_en,
  input wire logic [5:0] uv_flag,
  input wire logic [5:0] ov_flag,
  input wire logic thermal_warn_flag,
  input wire logic thermal_shd_flag,
  input wire logic [3:0] fault_bits,
  input wire logic [2:0] state_code,
  input wire logic reset_out_n,
  input wire logic interrupt_out_n,
  input wire logic [23:0] pin_fn,
  input wire logic fn_wr_reject,
  input wire logic strap_done,
  input wire logic io_supply_bias_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] uvm;
  logic [5:0] ovm;
  logic wr_seen;
  logic watch;
  logic bad_fn;
  // mask shadow, so the entry check knows which outputs are watched
  always_ff @(posedge clk) begin
    if (rst) begin
      uvm <= 6'h3F;
      ovm <= 6'h3F;
      wr_seen <= 1'h0;
    end else if (mask_wr) begin
      uvm <= undervoltage_mask_bit_wr;
      ovm <= overvoltage_mask_bit_wr;
      wr_seen <= 1'h1;
    end
  end
  assign watch = |((out_uv | out_ov) & ~uvm & ~ovm)
    && !fault_shutdown_disable;
  assign bad_fn = fn_wr && (fn_wr_pin inside {[3'h1:3'h4]}
    || fn_wr_val == pfs_pkg::FN_MODE
    || (fn_wr_val == pfs_pkg::FN_BUTTON
      && !(fn_wr_pin inside {3'h5, 3'h6}))
    || (fn_wr_val == pfs_pkg::FN_LED && fn_wr_pin != 3'h7));
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  a_flags_live: assert property (!$past(rst) |->
    uv_flag == $past(out_uv) && ov_flag == $past(out_ov))
    else $error("uv or ov flag stale");
  a_therm_live: assert property (!$past(rst) |->
    thermal_warn_flag == $past(temp_warn)
    && thermal_shd_flag == $past(temp_shd))
    else $error("thermal flag stale");
  a_ovuv_entry: assert property (state_code == 3'h1 && watch |=>
    state_code == 3'h2 && rail_en == 6'h00)
    else $error("output fault did not shut rails");
  a_rst_out_low: assert property (state_code == 3'h2 |-> !reset_out_n)
    else $error("reset output high in output fault");
  a_irq_raise: assert property ($rose(|fault_bits) |=> !interrupt_out_n)
    else $error("interrupt late after fault bit");
  a_irq_release: assert property ($rose(interrupt_out_n) |->
    $past(fault_bits) == 4'h0)
    else $error("interrupt released with bits set");
  a_bits_sticky: assert property (!$past(rst) |->
    ($past(fault_bits) & ~fault_bits & ~$past(fault_read)) == 4'h0)
    else $error("fault bit cleared without read");
  a_fn_refused: assert property (bad_fn |=> fn_wr_reject
    && pin_fn == $past(pin_fn))
    else $error("illegal function write accepted");
  a_bias_off: assert property (strap_done |=> !io_supply_bias_en)
    else $error("bias still on after latch");
  a_masked_quiet: assert property (!wr_seen |-> interrupt_out_n)
    else $error("interrupt with reset masks");
  c_ovuv: cover property (state_code == 3'h1 ##1 state_code == 3'h2);
  c_therm: cover property (state_code == 3'h3);
  c_refused: cover property (fn_wr_reject);
endmodule : pfs_checker
`default_nettype wire

//--- dv/tb_pmic_fault_gpio_supervisor.sv
// self-checking bench for the fault and gpio supervisor
`default_nettype none
module tb_pmic_fault_gpio_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [5:0] out_uv, out_ov, overvoltage_mask_bit_wr, rail_en;
  logic [5:0] undervoltage_mask_bit_wr, uv_flag, ov_flag;
  logic [3:0] sw_cycle, buck_at_limit, current_limit_shutdown_enable;
  logic [3:0] current_limit_mask_bit_wr, current_limit_status;
  logic [3:0] fault_read, fault_bits;
  logic [7:0] pin_in, pin_float;
  logic [2:0] fn_wr_pin, fn_wr_val, state_code;
  logic [23:0] pin_fn;
  logic [15:0] strap_level;
  logic mask_wr, fault_shutdown_disable, buck1_warn_level, buck1_hard_level;
  logic temp_warn, temp_shd, thermal_warn_mask_wr, thermal_shd_mask_wr;
  logic input_overvoltage_level, power_seq_done, fn_wr, restart_seq;
  logic thermal_warn_flag, thermal_shd_flag, reset_out_n, interrupt_out_n;
  logic fn_wr_reject, strap_done, io_supply_bias_en;
  int bad_count = 0;
  int n_checks = 0;
  pfs_supervisor u_dut (.*);
  pfs_host_model u_host (.clk, .rst, .state_code, .power_seq_done);
  always #20 clk = ~clk;
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic do_reset();
    rst = 1'h1;
    tick(4);
    rst = 1'h0;
  endtask : do_reset
  task automatic set_masks(input logic m);
    {overvoltage_mask_bit_wr, undervoltage_mask_bit_wr} = {12{m}};
    current_limit_mask_bit_wr = {4{m}};
    {thermal_warn_mask_wr, thermal_shd_mask_wr} = {2{m}};
    mask_wr = 1'h1;
    tick(1);
    mask_wr = 1'h0;
  endtask : set_masks
  task automatic rd_faults();
    fault_read = 4'hF;
    tick(1);
    fault_read = 4'h0;
    tick(3);
  endtask : rd_faults
  // bounded wait; the sequencer model answers within twenty cycles
  task automatic wait_active();
    for (int i = 0; i < 200 && state_code !== 3'h1; i++) tick(1);
  endtask : wait_active
  task automatic pulse(input int b, input int n);
    repeat (n) begin
      sw_cycle[b] = 1'h1;
      tick(1);
      sw_cycle[b] = 1'h0;
      tick(2);
    end
  endtask : pulse
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_strap();
    chk("bias", 24'h1, io_supply_bias_en);
    for (int i = 0; i < 100 && strap_done !== 1'h1; i++) tick(1);
    tick(2);
    chk("strap", 24'h86, strap_level[9:2]);
    chk("bias", 24'h0, io_supply_bias_en);
    pin_in = 8'h0C;
    pin_float = 8'h10;
    tick(20);
    chk("strap", 24'h86, strap_level[9:2]);
    chk("fn", pfs_pkg::FN_DEFAULT, pin_fn);
  endtask : t_strap
  task automatic t_gpio();
    logic [6:0] tb_w [11] = '{7'h02, 7'h48, 7'h2D, 7'h35, 7'h45, 7'h3E,
                              7'h6E, 7'h7F, 7'h34, 7'h29, 7'h3B};
    logic [23:0] exp_fn;
    exp_fn = pfs_pkg::FN_DEFAULT;
    foreach (tb_w[i]) begin
      {fn_wr_pin, fn_wr_val} = tb_w[i][5:0];
      fn_wr = 1'h1;
      tick(1);
      if (!tb_w[i][6]) exp_fn[fn_wr_pin*3+:3] = fn_wr_val;
      chk("reject", tb_w[i][6], fn_wr_reject);
      chk("fn", exp_fn, pin_fn);
    end
    fn_wr = 1'h0;
    do_reset();
    chk("fn", pfs_pkg::FN_DEFAULT, pin_fn);
  endtask : t_gpio
  task automatic t_masked();
    out_uv = 6'h04;
    out_ov = 6'h08;
    tick(3);
    chk("uv flag", 24'h04, uv_flag);
    chk("ov flag", 24'h08, ov_flag);
    chk("state", 24'h1, state_code);
    chk("irq", 24'h1, interrupt_out_n);
    chk("bits", 24'h0, fault_bits);
    {out_uv, out_ov} = 12'h000;
    tick(2);
  endtask : t_masked
  task automatic t_ocp();
    buck_at_limit[1] = 1'h1;
    pulse(1, 15);
    buck_at_limit[1] = 1'h0;
    pulse(1, 1);
    buck_at_limit[1] = 1'h1;
    pulse(1, 15);
    chk("limit", 24'h0, current_limit_status[1]);
    pulse(1, 1);
    chk("limit", 24'h1, current_limit_status[1]);
    chk("irq", 24'h1, interrupt_out_n);
    buck_at_limit[1] = 1'h0;
    {buck1_warn_level, buck1_hard_level} = 2'h2;
    pulse(0, 16);
    chk("limit", 24'h0, current_limit_status[0]);
    pulse(0, 1);
    chk("limit", 24'h1, current_limit_status[0]);
    {buck1_warn_level, buck1_hard_level} = 2'h3;
    pulse(0, 2);
    chk("buck1 rail", 24'h1, rail_en[0]);
    pulse(0, 1);
    tick(1);
    chk("buck1 rail", 24'h0, rail_en[0]);
    {buck1_warn_level, buck1_hard_level} = 2'h0;
  endtask : t_ocp
  task automatic t_uvov();
    do_reset();
    wait_active();
    set_masks(1'h0);
    fault_shutdown_disable = 1'h1;
    out_uv = 6'h02;
    tick(3);
    chk("state", 24'h1, state_code);
    out_uv = 6'h00;
    fault_shutdown_disable = 1'h0;
    tick(1);
    rd_faults();
    out_ov = 6'h10;
    tick(1);
    chk("state", 24'h2, state_code);
    chk("rails", 24'h0, rail_en);
    chk("reset out", 24'h0, reset_out_n);
    out_ov = 6'h00;
    tick(3);
    chk("bits", 24'h1, fault_bits[0]);
    chk("irq", 24'h0, interrupt_out_n);
    rd_faults();
    chk("irq", 24'h1, interrupt_out_n);
    tick(1000);
    chk("state", 24'h2, state_code);
  endtask : t_uvov
  task automatic t_therm();
    do_reset();
    wait_active();
    {temp_warn, temp_shd} = 2'h3;
    tick(3);
    chk("warn flag", 24'h1, thermal_warn_flag);
    chk("shd flag", 24'h1, thermal_shd_flag);
    chk("state", 24'h1, state_code);
    chk("irq", 24'h1, interrupt_out_n);
    {temp_warn, temp_shd} = 2'h0;
    set_masks(1'h0);
    temp_warn = 1'h1;
    tick(3);
    chk("irq", 24'h0, interrupt_out_n);
    temp_warn = 1'h0;
    tick(1);
    rd_faults();
    temp_shd = 1'h1;
    tick(1);
    chk("state", 24'h3, state_code);
    chk("rails", 24'h0, rail_en);
    temp_shd = 1'h0;
    wait_active();
    chk("state", 24'h1, state_code);
  endtask : t_therm
  task automatic t_vinov();
    input_overvoltage_level = 1'h1;
    tick(2);
    chk("state", 24'h4, state_code);
    input_overvoltage_level = 1'h0;
    tick(1);
    chk("restart", 24'h1, restart_seq);
    tick(1);
    chk("state", 24'h0, state_code);
    wait_active();
    chk("state", 24'h1, state_code);
  endtask : t_vinov
  initial begin
    {out_uv, out_ov, overvoltage_mask_bit_wr} = '0;
    {undervoltage_mask_bit_wr, sw_cycle, buck_at_limit} = '0;
    {current_limit_shutdown_enable, current_limit_mask_bit_wr} = '0;
    {fault_read, fn_wr_pin, fn_wr_val, mask_wr, fn_wr} = '0;
    {fault_shutdown_disable, buck1_warn_level, buck1_hard_level} = '0;
    {temp_warn, temp_shd, thermal_warn_mask_wr, thermal_shd_mask_wr} = '0;
    input_overvoltage_level = 1'h0;
    pin_in = 8'h12;
    pin_float = 8'h04;
    do_reset();
    t_strap();
    t_gpio();
    wait_active();
    t_masked();
    t_ocp();
    t_uvov();
    t_therm();
    t_vinov();
    tally_and_finish();
  end
  // the whole run takes under two thousand cycles
  initial begin
    #2_000_000;
    bad_count++;
    tally_and_finish();
  end
endmodule : tb_pmic_fault_gpio_supervisor
bind pfs_supervisor pfs_checker u_chk (.*);
`default_nettype wire
